/* File: src/lrx_pkg.sv */
// lrx_pkg: opcodes, widths, reset values and timing for the literal/return/rotate executor
// assumes a 12-bit instruction word fed one per instruction cycle by the fetch stage
package lrx_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int BANK_W = 3;
  localparam int FADDR_W = 5;
  localparam int INSTR_W = 12;
  localparam int STACK_DEPTH = 4;
  localparam int SP_W = 3;
  // opcodes, 12-bit encodings and high-bit prefixes
  localparam logic [11:0] OP_NOP = 12'h000;
  localparam logic [11:0] OP_OPTION = 12'h002;
  localparam logic [11:0] OP_RETURN = 12'h01e;
  localparam logic [11:0] OP_INT_RETURN = 12'h01f;
  localparam logic [8:0] OP_BANK_LOAD_HI = 9'h002; // instr[11:3]
  localparam logic [3:0] OP_WORK_LOAD_HI = 4'hc; // instr[11:8]
  localparam logic [3:0] OP_LIT_RETURN_HI = 4'h8; // instr[11:8]
  localparam logic [5:0] OP_ROT_RIGHT_HI = 6'h0c; // instr[11:6]
  localparam logic [5:0] OP_ROT_LEFT_HI = 6'h0d; // instr[11:6]
  // field positions
  localparam int DEST_BIT = 5;
  localparam int INT_ENABLE_BIT = 7;
  // reset values
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam logic [7:0] INTCON_RST = 8'h00;
  localparam logic [10:0] PC_RST = 11'h000;
  // branch cost in instruction cycles
  localparam int BRANCH_CYCLES = 2;
endpackage

/* File: src/lrx_stack.sv */
// lrx_stack: hardware return stack, push and pop
// assumes the executor never pushes and pops in one cycle
`timescale 1ns/1ps
module lrx_stack (
  input wire logic clock, // core clock
  input wire logic rstn, // sync reset, active low
  input wire logic push, // push ret_in
  input wire logic pop, // drop top entry
  input wire logic [10:0] ret_in, // address pushed
  output logic [10:0] top_of_stack, // current top entry
  output logic [2:0] depth // entries held
);
  logic [10:0] mem_reg [lrx_pkg::STACK_DEPTH];
  logic [2:0] sp_reg;
  wire [1:0] top_idx = sp_reg[1:0] - 2'h1;
  assign top_of_stack = mem_reg[top_idx];
  assign depth = sp_reg;

  // pointer: pop exposes the entry below, push holds the pointer at four when full
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sp_reg <= 3'h0;
    end else if (push && sp_reg != 3'h4) begin
      sp_reg <= sp_reg + 3'h1;
    end else if (pop && sp_reg != 3'h0) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  // storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[sp_reg[1:0]] <= ret_in;
    end
  end
endmodule

/* File: src/lrx_exec.sv */
// lrx_exec: executes NOP, literal loads, option load, returns and rotates
// assumes instr_valid marks a fetched word; file reads are combinational via file_rdata
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
module lrx_exec (
  input wire logic clock, // core clock, 200 MHz
  input wire logic rstn, // sync reset, active low
  input wire logic instr_valid, // instr holds a fetched word
  input wire logic [11:0] instr, // instruction word
  input wire logic call_push, // external call pushes pc
  input wire logic [7:0] file_rdata, // data at file_addr
  output logic [4:0] file_addr, // file register address
  output logic [7:0] file_wdata, // file write data
  output logic file_we, // file write strobe, one cycle
  output logic [10:0] pc, // program counter
  output logic [7:0] working, // working register
  output logic [7:0] option_reg_out, // option register
  output logic [2:0] bank_select_register, // bank select
  output logic [7:0] interrupt_control_register, // interrupt control
  output logic carry, // carry flag
  output logic flush // prefetched word discarded
);
  ////////////////////////////////////////////////////////////////////////
  logic [10:0] pc_reg, pc_next;
  logic [7:0] w_reg, w_next, opt_reg, opt_next, intc_reg, intc_next;
  logic [2:0] bank_reg, bank_next;
  logic c_reg, c_next, flush_reg, flush_next, fwe_reg, fwe_next;
  logic [7:0] fwd_reg, fwd_next;
  logic [10:0] stack_top;
  logic [2:0] depth;

  // decode
  wire run = instr_valid && !flush_reg;
  wire is_nop = run && instr == lrx_pkg::OP_NOP;
  wire is_opt = run && instr == lrx_pkg::OP_OPTION;
  wire is_ret = run && instr == lrx_pkg::OP_RETURN;
  wire is_rfie = run && instr == lrx_pkg::OP_INT_RETURN;
  wire is_bank_load = run && instr[11:3] == lrx_pkg::OP_BANK_LOAD_HI;
  wire is_work_load = run && instr[11:8] == lrx_pkg::OP_WORK_LOAD_HI;
  wire is_lit_ret = run && instr[11:8] == lrx_pkg::OP_LIT_RETURN_HI;
  wire is_rot_right = run && instr[11:6] == lrx_pkg::OP_ROT_RIGHT_HI;
  wire is_rot_left = run && instr[11:6] == lrx_pkg::OP_ROT_LEFT_HI;
  wire any_ret = is_ret || is_rfie || is_lit_ret;
  wire rot = is_rot_right || is_rot_left;
  wire to_file = instr[lrx_pkg::DEST_BIT];
  wire [2:0] bank_lit = instr[2:0];
  wire [7:0] lit8 = instr[7:0];
  // file address stays combinational so the file read lands in the same cycle
  wire [4:0] faddr = instr[4:0];
  // nine-bit rotation through carry
  wire [7:0] rot_val = is_rot_left ? {file_rdata[6:0], c_reg} : {c_reg, file_rdata[7:1]};
  wire rot_c = is_rot_left ? file_rdata[7] : file_rdata[0];

  assign file_addr = faddr;

  ////////////////////////////////////////////////////////////////////////
  // return stack
  lrx_stack lrx_stack_inst (
    .clock(clock),
    .rstn(rstn),
    .push(call_push && run),
    .pop(any_ret),
    .ret_in(pc_reg),
    .top_of_stack(stack_top),
    .depth(depth)
  );

  // next-state logic
  always_comb begin
    pc_next = run ? pc_reg + 11'h1 : pc_reg;
    w_next = w_reg;
    opt_next = opt_reg;
    intc_next = intc_reg;
    bank_next = bank_reg;
    c_next = c_reg;
    flush_next = 1'b0;
    fwe_next = 1'b0;
    fwd_next = fwd_reg;
    if (is_bank_load) begin
      bank_next = bank_lit;
    end
    if (is_work_load) begin
      w_next = lit8;
    end
    if (is_opt) begin
      opt_next = w_reg;
    end
    if (any_ret) begin
      pc_next = stack_top;
      flush_next = 1'b1;
    end
    if (is_rfie) begin
      intc_next[lrx_pkg::INT_ENABLE_BIT] = 1'b1;
    end
    if (is_lit_ret) begin
      w_next = lit8;
    end
    if (rot) begin
      c_next = rot_c;
      if (to_file) begin
        fwe_next = 1'b1;
        fwd_next = rot_val;
      end else begin
        w_next = rot_val;
      end
    end
  end

  // state registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pc_reg <= lrx_pkg::PC_RST;
      w_reg <= lrx_pkg::W_RST;
      opt_reg <= lrx_pkg::OPTION_RST;
      intc_reg <= lrx_pkg::INTCON_RST;
      bank_reg <= lrx_pkg::BANK_RST;
      c_reg <= 1'b0;
      flush_reg <= 1'b0;
      fwe_reg <= 1'b0;
      fwd_reg <= 8'h00;
    end else begin
      pc_reg <= pc_next;
      w_reg <= w_next;
      opt_reg <= opt_next;
      intc_reg <= intc_next;
      bank_reg <= bank_next;
      c_reg <= c_next;
      flush_reg <= flush_next;
      fwe_reg <= fwe_next;
      fwd_reg <= fwd_next;
    end
  end

  assign pc = pc_reg;
  assign working = w_reg;
  assign option_reg_out = opt_reg;
  assign interrupt_control_register = intc_reg;
  assign bank_select_register = bank_reg;
  assign carry = c_reg;
  assign flush = flush_reg;
  assign file_we = fwe_reg;
  assign file_wdata = fwd_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence ret_seen;
    any_ret;
  endsequence
  bank_load_a: assert property (@(posedge clock) disable iff (!rstn)
    is_bank_load |=> bank_reg == $past(bank_lit) && c_reg == $past(c_reg))
    else $error("bank load wrong");
  work_load_a: assert property (@(posedge clock) disable iff (!rstn)
    is_work_load |=> w_reg == $past(lit8) && c_reg == $past(c_reg))
    else $error("working load wrong");
  option_load_a: assert property (@(posedge clock) disable iff (!rstn)
    is_opt |=> opt_reg == $past(w_reg))
    else $error("option load wrong");
  interrupt_return_gie_a: assert property (@(posedge clock) disable iff (!rstn)
    is_rfie |=> intc_reg[lrx_pkg::INT_ENABLE_BIT] && pc_reg == $past(stack_top))
    else $error("interrupt return wrong");
  ret_flush_a: assert property (@(posedge clock) disable iff (!rstn)
    ret_seen |=> flush_reg ##1 !flush_reg)
    else $error("return not two cycles");
  literal_return_load_a: assert property (@(posedge clock) disable iff (!rstn)
    is_lit_ret |=> w_reg == $past(lit8) && pc_reg == $past(stack_top) && c_reg == $past(c_reg))
    else $error("literal return wrong");
  plain_ret_a: assert property (@(posedge clock) disable iff (!rstn)
    is_ret |=> intc_reg == $past(intc_reg) && c_reg == $past(c_reg))
    else $error("return touched flags");
  rotate_carry_a: assert property (@(posedge clock) disable iff (!rstn)
    rot |=> c_reg == $past(rot_c))
    else $error("rotate carry wrong");
  rotate_dest_a: assert property (@(posedge clock) disable iff (!rstn)
    rot && to_file |=> file_we && file_wdata == $past(rot_val) && w_reg == $past(w_reg))
    else $error("rotate destination wrong");
  nop_advance_a: assert property (@(posedge clock) disable iff (!rstn)
    is_nop |=> pc_reg == $past(pc_reg) + 11'h1 && w_reg == $past(w_reg))
    else $error("nop changed state");
  ret_pop_a: assert property (@(posedge clock) disable iff (!rstn)
    any_ret && depth != 3'h0 |=> depth == $past(depth) - 3'h1)
    else $error("return did not pop");
endmodule

/* File: dv/lrx_exec_tb.sv */
// lrx_exec_tb: self-checking bench for the literal/return/rotate executor
// assumes lrx_exec holds its own return stack and shows results one cycle after a word
`timescale 1ns/1ps
module lrx_exec_tb;
  logic clock, rstn, instr_valid, call_push, file_we, carry, flush;
  logic [11:0] instr;
  logic [7:0] file_rdata, file_wdata, working, option_reg_out, interrupt_control_register;
  logic [4:0] file_addr;
  logic [10:0] pc;
  logic [2:0] bank_select_register;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // device under test
  lrx_exec lrx_exec_inst (
    .clock(clock), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .call_push(call_push), .file_rdata(file_rdata), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .pc(pc), .working(working),
    .option_reg_out(option_reg_out), .bank_select_register(bank_select_register),
    .interrupt_control_register(interrupt_control_register), .carry(carry), .flush(flush)
  );
  // 200 MHz core clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // cycle ceiling against a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures = failures + 1;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task end_of_test;
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // compare one value, report a mismatch
  task chk(input string name, input logic [10:0] seen, input logic [10:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // present one word at the current edge, taken at the next
  task ex(input logic [11:0] w, input logic p = 1'b0, input logic [7:0] fd = 8'h00);
    instr <= w;
    instr_valid <= 1'b1;
    call_push <= p;
    file_rdata <= fd;
    @(posedge clock);
  endtask
  // drop the request and let the taken edge settle
  task st;
    instr_valid <= 1'b0;
    call_push <= 1'b0;
    #1;
  endtask
  // one word alone, results settled on return
  task go(input logic [11:0] w, input logic p = 1'b0, input logic [7:0] fd = 8'h00);
    @(posedge clock);
    ex(w, p, fd);
    st();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn = 1'b0;
    instr_valid = 1'b0;
    call_push = 1'b0;
    instr = 12'h000;
    file_rdata = 8'h00;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk("pc", pc, 11'h000);
    chk("option", 11'(option_reg_out), 11'h0ff);
    chk("intctl", 11'(interrupt_control_register), 11'h000);
    go(12'hca5);
    chk("working", 11'(working), 11'h0a5);
    chk("pc", pc, 11'h001);
    go(12'h017);
    chk("bank", 11'(bank_select_register), 11'h007);
    chk("carry", 11'(carry), 11'h000);
    go(12'h002);
    chk("option", 11'(option_reg_out), 11'h0a5);
    go(12'h000, 1'b1);
    chk("pc", pc, 11'h004);
    chk("working", 11'(working), 11'h0a5);
    go(12'h000, 1'b1);
    // literal return, then a word in the flush cycle that must be dropped
    @(posedge clock);
    ex(12'h83c);
    ex(12'hcff);
    st();
    chk("working", 11'(working), 11'h03c);
    chk("pc", pc, 11'h004);
    go(12'h01f);
    chk("pc", pc, 11'h003);
    chk("intctl", 11'(interrupt_control_register), 11'h080);
    chk("flush", 11'(flush), 11'h001);
    go(12'h000, 1'b1);
    go(12'h01e);
    chk("pc", pc, 11'h003);
    chk("flush", 11'(flush), 11'h001);
    chk("intctl", 11'(interrupt_control_register), 11'h080);
    // rotates through carry, both destinations
    go(12'h363, 1'b0, 8'h81);
    chk("addr", 11'(file_addr), 11'h003);
    chk("we", 11'(file_we), 11'h001);
    chk("wdata", 11'(file_wdata), 11'h002);
    chk("carry", 11'(carry), 11'h001);
    chk("working", 11'(working), 11'h03c);
    go(12'h31f, 1'b0, 8'h01);
    chk("addr", 11'(file_addr), 11'h01f);
    chk("we", 11'(file_we), 11'h000);
    chk("working", 11'(working), 11'h080);
    chk("carry", 11'(carry), 11'h001);
    go(12'h340, 1'b0, 8'h40);
    chk("working", 11'(working), 11'h081);
    chk("carry", 11'(carry), 11'h000);
    end_of_test();
  end
endmodule
